// >>> pmm_pkg.sv
// shared constants and carrier types of the management port
package pmm_pkg;
    localparam int PHY_W = 5;
    localparam int REG_W = 5;
    localparam int DATA_W = 16;
    localparam int NUM_REGS = 32;
    localparam int PREAMBLE_LEN = 32;
    localparam int OP_BITS = 2;
    localparam int ADDR_BITS = 10;
    localparam int STRAP_SETTLE = 2;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [4:0] ADDR_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_STATUS = 5'h01;
    localparam logic [4:0] ADDR_STRAP = 5'h10;
    localparam int CTRL_ISOLATE_BIT = 10;
    localparam int STATUS_PRE_SUPP_BIT = 6;
    localparam int STRAP_LSB = 6;
    localparam int STRAP_MSB = 10;
    localparam logic [15:0] STATUS_VALUE = 16'h6149;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [4:0] ISOLATE_ADDR = 5'h00;

    typedef enum logic [6:0] {
        ST_UNSYNC = 7'h01,
        ST_IDLE = 7'h02,
        ST_START = 7'h04,
        ST_OPCODE = 7'h08,
        ST_ADDR = 7'h10,
        ST_TURN = 7'h20,
        ST_DATA = 7'h40
    } pmm_state_type;

    typedef struct packed {
        logic txClk;
        logic rxClk;
        logic rxDv;
        logic rxEr;
        logic [3:0] rxd;
        logic crs;
        logic col;
    } pmm_mii_out_type;

    typedef struct packed {
        logic [3:0] txd;
        logic txEn;
        logic txEr;
    } pmm_mii_in_type;
endpackage : pmm_pkg

// >>> pmm_sync.sv
// two-stage level synchroniser
`timescale 1ns/100ps
module pmm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_reg;

    if (WIDTH < 1) begin : g_chk
        $error("pmm_sync width must be positive");
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_reg <= '0;
            syncOut <= '0;
        end else begin
            stage1_reg <= asyncIn;
            syncOut <= stage1_reg;
        end
    end
endmodule : pmm_sync

// >>> pmm_strap_latch.sv
// captures the address straps once after reset release
`timescale 1ns/100ps
module pmm_strap_latch (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [pmm_pkg::PHY_W-1:0] strapPins,
    output logic [pmm_pkg::PHY_W-1:0] phyAddr,
    output logic strapValid
);
    logic [pmm_pkg::PHY_W-1:0] pinsSync;
    logic [1:0] settle_reg;

    pmm_sync #(.WIDTH(pmm_pkg::PHY_W)) u_pins (
        .clk(clk),
        .reset_n(reset_n),
        .asyncIn(strapPins),
        .syncOut(pinsSync)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            settle_reg <= '0;
        end else if (settle_reg != 2'(pmm_pkg::STRAP_SETTLE)) begin
            settle_reg <= settle_reg + 2'h1;
        end
    end

    // the reset value of the synchroniser is not a strap, so wait it out
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phyAddr <= '0;
            strapValid <= 1'b0;
        end else if (settle_reg == 2'(pmm_pkg::STRAP_SETTLE) && !strapValid) begin
            phyAddr <= pinsSync; // R13
            strapValid <= 1'b1;
        end
    end
endmodule : pmm_strap_latch

// >>> pmm_mgmt_port.sv
// serial management port with strapped address and isolate control
// Function
// R01: controller clocks the management link at 2.5 MHz or slower.
// R02: controller sends 32 ones on the data line to initialise the port.
// R03: after reset every frame is ignored until the full preamble is seen.
// R04: bad start, opcode or turnaround drops sync; new preamble needed.
// R05: each frame starts with a zero then a one.
// R06: frame is start, opcode, phy address, register, turnaround, 16 data bits.
// R07: nobody drives the line in the first turnaround bit of a read.
// R08: addressed read drives zero in second turnaround bit, then data msb first.
// R09: controller drives one then zero in write turnaround, then the data.
// R10: status register bit 6 reads one to show preamble suppression.
// R11: back-to-back frames with a single idle bit between are accepted.
// R12: once synced, no further preamble until reset or a framing error.
// R13: five address straps are latched at reset into strap register bits 10:6.
// R14: any address 0 to 31 is valid; address zero forces isolate.
// R15: writing one to control bit 10 forces isolate.
// R16: isolate ignores transmit inputs and floats all interface outputs.
// R17: management frames keep working while isolated.
// R18: isolate leaves line side operation running.
// R19: up to 32 devices share the line, told apart by address.
// R20: thirty-two 16-bit registers selected by the register address field.
// R21: only frames carrying our address are answered; otherwise line stays free.
// R22: line sampled on rising management clock, changed only after that edge.
`timescale 1ns/100ps
module pmm_mgmt_port #(
    parameter int PREAMBLE_LEN = pmm_pkg::PREAMBLE_LEN
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic mdcClk,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe_n,
    input wire logic [pmm_pkg::PHY_W-1:0] strapPins,
    input pmm_pkg::pmm_mii_out_type miiCoreOut,
    output pmm_pkg::pmm_mii_out_type miiPadOut,
    output logic miiPadOe_n,
    input pmm_pkg::pmm_mii_in_type miiPadIn,
    output pmm_pkg::pmm_mii_in_type miiCoreIn,
    output logic isolated,
    output logic [pmm_pkg::PHY_W-1:0] phyAddr
);
    localparam logic [4:0] LAST_PRE = 5'(PREAMBLE_LEN - 1);
    localparam logic [3:0] LAST_ADDR = 4'(pmm_pkg::ADDR_BITS - 1);
    localparam logic [3:0] LAST_DATA = 4'(pmm_pkg::DATA_W - 1);

    if (PREAMBLE_LEN < 1 || PREAMBLE_LEN > 32) begin : g_chk
        $error("preamble length must lie in 1..32");
    end

    pmm_pkg::pmm_state_type state_reg;
    logic [4:0] cnt_reg;
    logic [15:0] shiftIn_reg;
    logic [15:0] txShift_reg;
    logic opRead_reg;
    logic phyMatch_reg;
    logic [4:0] regAddr_reg;
    logic [4:0] phyLink_reg;
    logic strapOk_reg;
    logic strapValid;
    logic strapValidLink;
    logic isoCtrlSync;
    logic [15:0] regFile_reg [pmm_pkg::NUM_REGS];
    logic [1:0] opWord;
    logic [9:0] addrWord;
    logic [15:0] dataWord;
    logic readHit;

    function automatic logic [15:0] readWord(
        input logic [4:0] addr,
        input logic [15:0] stored,
        input logic [4:0] pa
    );
        logic [15:0] w;
        w = stored;
        if (addr == pmm_pkg::ADDR_STATUS) begin
            w = pmm_pkg::STATUS_VALUE; // R10
        end else if (addr == pmm_pkg::ADDR_STRAP) begin
            w[pmm_pkg::STRAP_MSB:pmm_pkg::STRAP_LSB] = pa; // R13
        end
        return w;
    endfunction : readWord

    pmm_strap_latch u_strap (
        .clk(clk),
        .reset_n(reset_n),
        .strapPins(strapPins),
        .phyAddr(phyAddr),
        .strapValid(strapValid)
    );

    pmm_sync #(.WIDTH(1)) u_valid_sync (
        .clk(mdcClk),
        .reset_n(reset_n),
        .asyncIn(strapValid),
        .syncOut(strapValidLink)
    );

    pmm_sync #(.WIDTH(1)) u_iso_sync (
        .clk(clk),
        .reset_n(reset_n),
        .asyncIn(regFile_reg[pmm_pkg::ADDR_CONTROL][pmm_pkg::CTRL_ISOLATE_BIT]),
        .syncOut(isoCtrlSync)
    );

    assign opWord = {shiftIn_reg[0], mdioIn};
    assign addrWord = {shiftIn_reg[8:0], mdioIn};
    assign dataWord = {shiftIn_reg[14:0], mdioIn};
    assign readHit = opRead_reg && phyMatch_reg;

    // the address word is held still in the clock domain once valid, so
    // only the valid flag needs synchronising
    always_ff @(posedge mdcClk or negedge reset_n) begin
        if (!reset_n) begin
            phyLink_reg <= '0;
            strapOk_reg <= 1'b0;
        end else if (strapValidLink && !strapOk_reg) begin
            phyLink_reg <= phyAddr;
            strapOk_reg <= 1'b1;
        end
    end

    // frame sequencer; isolate has no say here, frames run regardless
    always_ff @(posedge mdcClk or negedge reset_n) begin // R22 R17
        if (!reset_n) begin
            state_reg <= pmm_pkg::ST_UNSYNC;
            cnt_reg <= '0;
        end else begin
            case (state_reg)
                pmm_pkg::ST_UNSYNC: begin
                    if (!mdioIn) begin
                        cnt_reg <= '0; // R03
                    end else if (cnt_reg != LAST_PRE) begin
                        cnt_reg <= cnt_reg + 5'h01; // R02
                    end else if (strapOk_reg) begin
                        state_reg <= pmm_pkg::ST_IDLE; // R03
                        cnt_reg <= '0;
                    end
                end
                pmm_pkg::ST_IDLE: begin
                    if (!mdioIn) begin
                        state_reg <= pmm_pkg::ST_START; // R05 R11 R12
                    end
                end
                pmm_pkg::ST_START: begin
                    state_reg <= mdioIn ? pmm_pkg::ST_OPCODE : pmm_pkg::ST_UNSYNC; // R04 R05
                end
                pmm_pkg::ST_OPCODE: begin
                    if (cnt_reg == '0) begin
                        cnt_reg <= 5'h01;
                    end else begin
                        cnt_reg <= '0;
                        if (opWord == pmm_pkg::OP_READ || opWord == pmm_pkg::OP_WRITE) begin
                            state_reg <= pmm_pkg::ST_ADDR; // R06
                        end else begin
                            state_reg <= pmm_pkg::ST_UNSYNC; // R04
                        end
                    end
                end
                pmm_pkg::ST_ADDR: begin
                    if (cnt_reg[3:0] == LAST_ADDR) begin
                        cnt_reg <= '0;
                        state_reg <= pmm_pkg::ST_TURN;
                    end else begin
                        cnt_reg <= cnt_reg + 5'h01;
                    end
                end
                pmm_pkg::ST_TURN: begin
                    // a read turnaround belongs to the pull-up and to us, so
                    // only a write turnaround can be checked
                    if (cnt_reg == '0) begin
                        cnt_reg <= 5'h01;
                        if (!opRead_reg && !mdioIn) begin
                            state_reg <= pmm_pkg::ST_UNSYNC; // R04 R09
                            cnt_reg <= '0;
                        end
                    end else begin
                        cnt_reg <= '0;
                        if (!opRead_reg && mdioIn) begin
                            state_reg <= pmm_pkg::ST_UNSYNC; // R04 R09
                        end else begin
                            state_reg <= pmm_pkg::ST_DATA;
                        end
                    end
                end
                pmm_pkg::ST_DATA: begin
                    if (cnt_reg[3:0] == LAST_DATA) begin
                        cnt_reg <= '0;
                        state_reg <= pmm_pkg::ST_IDLE; // R11
                    end else begin
                        cnt_reg <= cnt_reg + 5'h01;
                    end
                end
                default: begin
                    state_reg <= pmm_pkg::ST_UNSYNC;
                    cnt_reg <= '0;
                end
            endcase
        end
    end

    // field capture
    always_ff @(posedge mdcClk or negedge reset_n) begin
        if (!reset_n) begin
            shiftIn_reg <= '0;
            opRead_reg <= 1'b0;
            phyMatch_reg <= 1'b0;
            regAddr_reg <= '0;
        end else begin
            shiftIn_reg <= dataWord;
            if (state_reg == pmm_pkg::ST_OPCODE && cnt_reg != '0) begin
                opRead_reg <= (opWord == pmm_pkg::OP_READ);
            end
            if (state_reg == pmm_pkg::ST_ADDR && cnt_reg[3:0] == LAST_ADDR) begin
                phyMatch_reg <= (addrWord[9:5] == phyLink_reg); // R19 R21
                regAddr_reg <= addrWord[4:0]; // R20
            end
        end
    end

    // register storage; status and strap fields are overlaid on read
    always_ff @(posedge mdcClk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < pmm_pkg::NUM_REGS; i++) begin
                regFile_reg[i] <= pmm_pkg::REG_RESET;
            end
        end else if (state_reg == pmm_pkg::ST_DATA && cnt_reg[3:0] == LAST_DATA
                     && !opRead_reg && phyMatch_reg) begin
            regFile_reg[regAddr_reg] <= dataWord; // R20 R15
        end
    end

    // line driver; changes only on the rising edge, a full period ahead
    // of the controller's sampling edge
    always_ff @(posedge mdcClk or negedge reset_n) begin
        if (!reset_n) begin
            mdioOut <= 1'b1;
            mdioOe_n <= 1'b1;
            txShift_reg <= '0;
        end else if (state_reg == pmm_pkg::ST_TURN && cnt_reg == '0 && readHit) begin
            mdioOut <= 1'b0; // R08
            mdioOe_n <= 1'b0;
            txShift_reg <= readWord(regAddr_reg, regFile_reg[regAddr_reg], phyLink_reg);
        end else if ((state_reg == pmm_pkg::ST_TURN && cnt_reg != '0 && readHit)
                     || (state_reg == pmm_pkg::ST_DATA && cnt_reg[3:0] != LAST_DATA && !mdioOe_n)) begin
            mdioOut <= txShift_reg[15]; // R08
            txShift_reg <= {txShift_reg[14:0], 1'b0};
        end else begin
            mdioOut <= 1'b1; // R07 R21
            mdioOe_n <= 1'b1;
        end
    end

    // isolate: only the pads are cut; the core keeps running its line side
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            isolated <= 1'b0;
        end else begin
            isolated <= isoCtrlSync || (strapValid && phyAddr == pmm_pkg::ISOLATE_ADDR); // R14 R15
        end
    end

    assign miiPadOut = miiCoreOut;
    assign miiPadOe_n = isolated; // R16
    assign miiCoreIn = isolated ? '0 : miiPadIn; // R16 R18

    unsync_quiet_a: // R03
    assert property (@(posedge mdcClk) disable iff (!reset_n)
        state_reg == pmm_pkg::ST_UNSYNC |-> mdioOe_n)
    else $error("line driven while unsynchronised");

    preamble_len_a: // R03
    assert property (@(posedge mdcClk) disable iff (!reset_n)
        $past(state_reg) == pmm_pkg::ST_UNSYNC && state_reg == pmm_pkg::ST_IDLE
        |-> $past(cnt_reg) == LAST_PRE && $past(mdioIn))
    else $error("synchronised without a full preamble");

    bad_start_a: // R04
    assert property (@(posedge mdcClk) disable iff (!reset_n)
        state_reg == pmm_pkg::ST_START && !mdioIn |=> state_reg == pmm_pkg::ST_UNSYNC)
    else $error("bad start code kept sync");

    bad_op_a: // R04
    assert property (@(posedge mdcClk) disable iff (!reset_n)
        state_reg == pmm_pkg::ST_OPCODE && cnt_reg != '0 && opWord != pmm_pkg::OP_READ
        && opWord != pmm_pkg::OP_WRITE |=> state_reg == pmm_pkg::ST_UNSYNC)
    else $error("bad opcode kept sync");

    ta_release_a: // R07
    assert property (@(posedge mdcClk) disable iff (!reset_n)
        state_reg == pmm_pkg::ST_ADDR && cnt_reg[3:0] == LAST_ADDR |=> mdioOe_n)
    else $error("line driven in first turnaround bit");

    ta_zero_a: // R08
    assert property (@(posedge mdcClk) disable iff (!reset_n)
        state_reg == pmm_pkg::ST_TURN && cnt_reg == '0 && readHit
        |=> (!mdioOe_n && !mdioOut) ##1 (!mdioOe_n && mdioOut == $past(txShift_reg[15])))
    else $error("turnaround zero or first data bit wrong");

    read_span_a: // R08
    assert property (@(posedge mdcClk) disable iff (!reset_n)
        state_reg == pmm_pkg::ST_TURN && cnt_reg == '0 && readHit
        |-> ##17 !mdioOe_n ##1 mdioOe_n)
    else $error("read drive length wrong");

    mismatch_quiet_a: // R21
    assert property (@(posedge mdcClk) disable iff (!reset_n)
        !phyMatch_reg && (state_reg == pmm_pkg::ST_TURN || state_reg == pmm_pkg::ST_DATA)
        |-> mdioOe_n)
    else $error("line driven for another address");

    stay_sync_a: // R12
    assert property (@(posedge mdcClk) disable iff (!reset_n)
        state_reg == pmm_pkg::ST_IDLE && mdioIn |=> state_reg == pmm_pkg::ST_IDLE)
    else $error("sync lost on idle line");

    write_commit_a: // R20
    assert property (@(posedge mdcClk) disable iff (!reset_n)
        state_reg == pmm_pkg::ST_DATA && cnt_reg[3:0] == LAST_DATA && !opRead_reg && phyMatch_reg
        |=> regFile_reg[$past(regAddr_reg)] == $past(dataWord))
    else $error("write data not stored");

    iso_ctrl_a: // R15
    assert property (@(posedge clk) disable iff (!reset_n)
        isoCtrlSync |=> isolated && miiPadOe_n && miiCoreIn == '0)
    else $error("control isolate not applied");

    strap_zero_a: // R14
    assert property (@(posedge clk) disable iff (!reset_n)
        strapValid && phyAddr == pmm_pkg::ISOLATE_ADDR |=> isolated)
    else $error("address zero not isolated");

    read_done_c: cover property (@(posedge mdcClk) disable iff (!reset_n)
        state_reg == pmm_pkg::ST_DATA && cnt_reg[3:0] == LAST_DATA && readHit);
    write_done_c: cover property (@(posedge mdcClk) disable iff (!reset_n)
        state_reg == pmm_pkg::ST_DATA && cnt_reg[3:0] == LAST_DATA && !opRead_reg && phyMatch_reg);
    resync_c: cover property (@(posedge mdcClk) disable iff (!reset_n)
        state_reg == pmm_pkg::ST_START ##1 state_reg == pmm_pkg::ST_UNSYNC);
endmodule : pmm_mgmt_port

// >>> pmm_sta_model.sv
// station management controller model driving the serial management link
`timescale 1ns/100ps
module pmm_sta_model (
    output logic mdcClk,
    output logic mdioLine,
    input wire logic phyOut,
    input wire logic phyOe_n
);
    logic staOe;
    logic staOut;
    logic turnBit;
    logic [31:0] drvSeen;
    logic [15:0] rdData;

    // pull-up wins when nobody drives; two drivers resolve as a wired and
    assign mdioLine = (staOe ? staOut : 1'h1) & (phyOe_n ? 1'h1 : phyOut);

    initial begin
        mdcClk = 1'h0;
        staOe = 1'h0;
        staOut = 1'h1;
    end

    // clock stands still between calls; the bench rate is above the line limit to keep runs short
    task automatic send_bit(input logic drive, input logic val, output logic seen, output logic phyDrv);
        staOe = drive;
        staOut = val;
        #62;
        seen = mdioLine;
        phyDrv = !phyOe_n;
        mdcClk = 1'h1;
        #63;
        mdcClk = 1'h0;
    endtask : send_bit

    // a driven zero pair where a start code belongs breaks the frame
    task automatic zeros(input int n);
        logic s;
        logic d;
        repeat (n) send_bit(1'h1, 1'h0, s, d);
    endtask : zeros

    task automatic preamble(input int n);
        logic s;
        logic d;
        repeat (n) send_bit(1'h0, 1'h1, s, d);
    endtask : preamble

    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [1:0] ta, input logic [15:0] wd);
        logic [31:0] bits;
        logic seen;
        logic drv;
        logic rd;
        bits = {2'h1, op, pa, ra, ta, wd};
        rd = (op == 2'h2);
        for (int i = 0; i < 32; i++) begin
            send_bit(!(rd && i >= 14), bits[31-i], seen, drv);
            drvSeen[i] = drv;
            if (i == 15) turnBit = seen;
            if (i >= 16) rdData[31-i] = seen;
        end
        send_bit(1'h0, 1'h1, seen, drv);
    endtask : frame
endmodule : pmm_sta_model

// >>> testbench.sv
// self-checking bench for the management port
`timescale 1ns/100ps
module testbench;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic mdcClk, mdioLine, mdioOut, mdioOe_n, miiPadOe_n, isolated;
    logic [4:0] strapPins = 5'h05;
    logic [4:0] phyAddr;
    logic [15:0] got;
    pmm_pkg::pmm_mii_out_type miiCoreOut = '0;
    pmm_pkg::pmm_mii_out_type miiPadOut;
    pmm_pkg::pmm_mii_in_type miiPadIn = '0;
    pmm_pkg::pmm_mii_in_type miiCoreIn;
    int error_cnt = 0;
    int tests_run = 0;
    localparam logic [4:0] MY_ADDR = 5'h05;
    localparam logic [31:0] ANSWER = 32'hffff8000;

    always #50 clk = ~clk;

    pmm_mgmt_port #(.PREAMBLE_LEN(pmm_pkg::PREAMBLE_LEN)) u_pmm_mgmt_port (.clk(clk), .reset_n(reset_n),
        .mdcClk(mdcClk), .mdioIn(mdioLine), .mdioOut(mdioOut), .mdioOe_n(mdioOe_n), .strapPins(strapPins),
        .miiCoreOut(miiCoreOut), .miiPadOut(miiPadOut), .miiPadOe_n(miiPadOe_n), .miiPadIn(miiPadIn),
        .miiCoreIn(miiCoreIn), .isolated(isolated), .phyAddr(phyAddr));
    pmm_sta_model u_pmm_sta_model (.mdcClk(mdcClk), .mdioLine(mdioLine), .phyOut(mdioOut),
        .phyOe_n(mdioOe_n));

    task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask : check

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    task automatic rd(input logic [4:0] pa, input logic [4:0] ra);
        u_pmm_sta_model.frame(pmm_pkg::OP_READ, pa, ra, 2'h3, 16'h0000);
        got = u_pmm_sta_model.rdData;
    endtask : rd

    task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
        u_pmm_sta_model.frame(pmm_pkg::OP_WRITE, pa, ra, 2'h2, d);
    endtask : wr

    task automatic do_reset(input logic [4:0] strap);
        @(posedge clk);
        strapPins <= strap;
        reset_n <= 1'h0;
        u_pmm_sta_model.preamble(3);
        repeat (3) @(posedge clk);
        check({31'h0, mdioOe_n}, 32'h1, "oe during reset");
        reset_n <= 1'h1;
        repeat (8) @(posedge clk);
    endtask : do_reset

    task automatic t_reset_values();
        do_reset(MY_ADDR);
        check({27'h0, phyAddr}, {27'h0, MY_ADDR}, "strap address");
        check({30'h0, isolated, miiPadOe_n}, 32'h0, "not isolated");
        $display("reset values done");
    endtask : t_reset_values

    task automatic t_no_sync();
        rd(MY_ADDR, pmm_pkg::ADDR_STATUS);
        check(u_pmm_sta_model.drvSeen, 32'h0, "answer before preamble");
        $display("no sync done");
    endtask : t_no_sync

    task automatic t_status(input logic [4:0] pa);
        u_pmm_sta_model.preamble(32);
        rd(pa, pmm_pkg::ADDR_STATUS);
        check(u_pmm_sta_model.drvSeen, ANSWER, "read drive window");
        check({31'h0, u_pmm_sta_model.turnBit}, 32'h0, "turnaround zero");
        check({16'h0, got}, {16'h0, pmm_pkg::STATUS_VALUE}, "status");
        check({31'h0, got[6]}, 32'h1, "suppression bit");
        $display("status read done");
    endtask : t_status

    task automatic t_regs();
        logic [4:0] addrs [5] = '{5'h00, 5'h01, 5'h02, 5'h10, 5'h1f};
        logic [15:0] d;
        logic [15:0] e;
        foreach (addrs[i]) begin
            d = 16'h5a3c ^ {11'h000, addrs[i]};
            e = (addrs[i] == pmm_pkg::ADDR_STATUS) ? pmm_pkg::STATUS_VALUE : d;
            if (addrs[i] == pmm_pkg::ADDR_STRAP) e = (d & 16'hf83f) | {5'h00, MY_ADDR, 6'h00};
            wr(MY_ADDR, addrs[i], d);
            rd(MY_ADDR, addrs[i]);
            check({16'h0, got}, {16'h0, e}, "register readback");
        end
        $display("register map done");
    endtask : t_regs

    task automatic t_foreign();
        wr(5'h06, 5'h02, 16'hffff);
        rd(5'h06, 5'h02);
        check(u_pmm_sta_model.drvSeen, 32'h0, "foreign read");
        rd(MY_ADDR, 5'h02);
        check({16'h0, got}, 32'h00005a3e, "foreign write dropped");
        $display("foreign address done");
    endtask : t_foreign

    task automatic t_framing();
        u_pmm_sta_model.zeros(2);
        rd(MY_ADDR, 5'h02);
        check(u_pmm_sta_model.drvSeen, 32'h0, "after bad start");
        u_pmm_sta_model.preamble(32);
        u_pmm_sta_model.frame(2'h3, MY_ADDR, 5'h02, 2'h2, 16'h0000);
        rd(MY_ADDR, 5'h02);
        check(u_pmm_sta_model.drvSeen, 32'h0, "after bad opcode");
        u_pmm_sta_model.preamble(32);
        rd(MY_ADDR, 5'h02);
        check(u_pmm_sta_model.drvSeen, ANSWER, "resync");
        u_pmm_sta_model.frame(pmm_pkg::OP_WRITE, MY_ADDR, 5'h02, 2'h3, 16'h1111);
        rd(MY_ADDR, 5'h02);
        check(u_pmm_sta_model.drvSeen, 32'h0, "after bad turnaround");
        u_pmm_sta_model.preamble(32);
        rd(MY_ADDR, 5'h02);
        check({16'h0, got}, 32'h00005a3e, "bad write dropped");
        $display("framing errors done");
    endtask : t_framing

    task automatic t_isolate();
        @(posedge clk);
        miiPadIn <= '{txd: 4'ha, txEn: 1'h1, txEr: 1'h1};
        miiCoreOut <= 10'h2b6;
        @(posedge clk);
        check({22'h0, miiPadOut}, 32'h2b6, "pass through");
        wr(MY_ADDR, pmm_pkg::ADDR_CONTROL, 16'h0400);
        repeat (6) @(posedge clk);
        check({30'h0, isolated, miiPadOe_n}, 32'h3, "isolate on");
        check({26'h0, miiCoreIn}, 32'h0, "tx inputs ignored");
        rd(MY_ADDR, pmm_pkg::ADDR_CONTROL);
        check({16'h0, got}, 32'h00000400, "read while isolated");
        wr(MY_ADDR, pmm_pkg::ADDR_CONTROL, 16'h0000);
        repeat (6) @(posedge clk);
        check({26'h0, miiCoreIn, isolated, miiPadOe_n}, 32'hac, "isolate off");
        $display("isolate done");
    endtask : t_isolate

    task automatic t_strap_zero();
        do_reset(5'h00);
        check({26'h0, phyAddr, isolated}, 32'h1, "zero strap isolates");
        t_status(5'h00);
        $display("zero strap done");
    endtask : t_strap_zero

    initial begin
        #1000000;
        error_cnt++;
        $display("wrong value at %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        t_reset_values();
        t_no_sync();
        t_status(MY_ADDR);
        t_regs();
        t_foreign();
        t_framing();
        t_isolate();
        t_strap_zero();
        close_out();
    end
endmodule : testbench
